// ==== src/cdn_pkg.sv ====
package cdn_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int FLASH_TIME_MS = 200;
  localparam int NS_PER_MS = 1000000;
  localparam int FLASH_CYCLES = (FLASH_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int TICK_W = 24;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_DI_POL = 8'h00;
  localparam logic [7:0] REG_DO_POL = 8'h04;
  localparam logic [7:0] REG_DO_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DI_STATE = 8'h10;
  localparam logic [7:0] REG_NODE = 8'h14;
  localparam logic [7:0] REG_KBPS = 8'h18;
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] DO_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // switches and node id
  // ***************************************************************
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [6:0] DEC_BASE = 7'h0a;
  localparam logic [6:0] MAX_NODE_ID = 7'h63;
  localparam logic [6:0] FW_NODE_ID = 7'h00;
  localparam logic [6:0] NODE_ONE = 7'h01;
  localparam logic [1:0] SYNC_SETTLE = 2'h2;
  localparam int RATE_MODE_BIT = 3;
  localparam logic [15:0] KBPS_TABLE [8] = '{
    16'h000a, 16'h0014, 16'h0032, 16'h007d,
    16'h00fa, 16'h01f4, 16'h0320, 16'h03e8};

  // ***************************************************************
  // network management command specifiers
  // ***************************************************************
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;
  localparam logic [6:0] NMT_ALL_NODES = 7'h00;

  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_PREOP = 5'b00010,
    ST_OPER = 5'b00100,
    ST_STOP = 5'b01000,
    ST_FWUPD = 5'b10000
  } cdn_nmt_state_type;

  typedef enum logic [2:0] {
    LED_OFF = 3'h0,
    LED_ON = 3'h1,
    LED_BLINK = 3'h2,
    LED_SINGLE = 3'h3,
    LED_DOUBLE = 3'h4
  } cdn_led_mode_type;

  localparam logic [2:0] PHASE_LAST = 3'h5;
  localparam logic [2:0] PHASE_SECOND = 3'h2;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic valid;
    logic [6:0] node;
    logic [7:0] cs;
  } cdn_nmt_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cdn_pdo_type;

  typedef struct packed {
    logic valid;
    logic [6:0] id;
    logic [7:0] data;
  } cdn_peer_type;

  typedef struct packed {
    logic warn;
    logic guard;
    logic busoff;
  } cdn_err_type;

  typedef struct packed {
    logic [17:0] rsvd;
    cdn_err_type err;
    logic [2:0] rate;
    logic id_ok;
    logic fw;
    logic paired;
    cdn_nmt_state_type nmt;
  } cdn_status_type;

  typedef struct packed {
    logic [17:0] rsvd;
    logic [6:0] peer;
    logic [6:0] node;
  } cdn_node_reg_type;

endpackage

// ==== src/cdn_sync.sv ====
`timescale 1ns/1ps

module cdn_sync
  import cdn_pkg::*;
#(
  parameter int W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } cdn_sync_state_type;

  cdn_sync_state_type q;
  cdn_sync_state_type d;

  // first stage is read only by the second
  always_comb
  begin
    d = q;
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign sync_out = q.stable;

endmodule

// ==== src/cdn_led.sv ====
`timescale 1ns/1ps

module cdn_led
  import cdn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pattern step and chosen pattern
  input wire logic tick,
  input wire cdn_led_mode_type mode,
  // indicator
  output logic led
);

  typedef struct packed {
    logic [2:0] phase;
    logic led;
  } cdn_led_state_type;

  cdn_led_state_type q;
  cdn_led_state_type d;

  // six steps of one flash period: flash patterns share one frame
  always_comb
  begin
    d = q;
    if (tick)
    begin
      if (q.phase == PHASE_LAST)
        d.phase = '0;
      else
        d.phase = q.phase + 3'h1;
    end
    case (mode)
      LED_ON: d.led = 1'b1;
      LED_BLINK: d.led = ~d.phase[0];
      LED_SINGLE: d.led = (d.phase == '0);
      LED_DOUBLE: d.led = (d.phase == '0) || (d.phase == PHASE_SECOND);
      default: d.led = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign led = q.led;

endmodule

// ==== src/cdn_node.sv ====
`timescale 1ns/1ps

// Summary of operation
// - node id from tens and units switches
// - node ids up to 99 accepted
// - node id zero enters firmware update mode
// - rate codes 0-7 normal, 8-F paired
// - bit rate from code ignoring mode bit
// - eight inputs, eight outputs, selectable polarity
// - network management and process data services
// - peer input on drives same-index output
// - odd id pairs with odd plus one
// - paired mode goes operational by itself
// - run indicator follows management state
// - error indicator follows error state
module cdn_node
  import cdn_pkg::*;
#(
  parameter int FLASH_CYC = FLASH_CYCLES
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // rotary switches
  input wire logic [3:0] ID_TENS_SW,
  input wire logic [3:0] ID_UNITS_SW,
  input wire logic [3:0] RATE_SW,
  // field pins
  input wire logic [7:0] DIGITAL_INPUT_CHANNEL,
  output logic [7:0] DIGITAL_OUTPUT_CHANNEL,
  // protocol engine side
  input wire cdn_nmt_type NMT_IN,
  input wire cdn_pdo_type RX_PDO,
  input wire cdn_peer_type PEER_IN,
  input wire cdn_err_type ERR_IN,
  output cdn_pdo_type TX_PDO,
  // configuration seen by the engine
  output logic [6:0] NODE_ID,
  output logic [6:0] PEER_ID,
  output logic [2:0] BITRATE_IDX,
  output logic PAIRED_MODE,
  output logic FW_UPDATE,
  output cdn_nmt_state_type NMT_STATE,
  // indicators
  output logic RUN_LED,
  output logic ERR_LED
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] di_pol;
    logic [7:0] do_pol;
    logic [7:0] do_val;
    logic [7:0] do_pin;
    logic [7:0] di_prev;
    logic was_oper;
    cdn_pdo_type tx;
    cdn_nmt_state_type nmt;
    logic [6:0] node_id;
    logic [6:0] peer_id;
    logic id_ok;
    logic [2:0] rate;
    logic paired;
    cdn_led_mode_type run_mode;
    cdn_led_mode_type err_mode;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [1:0] settle;
    logic fw;
  } cdn_node_state_type;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(FLASH_CYC - 1);

  cdn_node_state_type q;
  cdn_node_state_type d;

  logic [7:0] di_sync;
  logic [3:0] tens_s;
  logic [3:0] units_s;
  logic [3:0] rate_s;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == REG_DI_POL) || (a == REG_DO_POL) ||
      (a == REG_DO_CMD) || (a == REG_STATUS) ||
      (a == REG_DI_STATE) || (a == REG_NODE) || (a == REG_KBPS);
  endfunction

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  cdn_sync #(
    .W(20)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .async_in({DIGITAL_INPUT_CHANNEL, ID_TENS_SW, ID_UNITS_SW, RATE_SW}),
    .sync_out({di_sync, tens_s, units_s, rate_s})
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    logic [7:0] di_state;
    logic [6:0] sw_id;
    logic [6:0] sw_peer;
    logic digits_ok;
    logic sw_paired;
    logic for_me;
    logic wr_ok;
    cdn_status_type st;
    cdn_node_reg_type nr;
    di_state = '0;
    sw_id = '0;
    sw_peer = '0;
    digits_ok = 1'b0;
    sw_paired = 1'b0;
    for_me = 1'b0;
    wr_ok = 1'b0;
    st = '0;
    nr = '0;
    d = q;
    d.tick = 1'b0;
    d.tx.valid = 1'b0;

    if (q.tick_cnt == TICK_LAST)
    begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end
    else
      d.tick_cnt = q.tick_cnt + TICK_W'(1);

    // polarity applied before anything looks at the inputs
    di_state = di_sync ^ q.di_pol;
    sw_id = 7'(tens_s) * DEC_BASE + 7'(units_s);
    digits_ok = (tens_s <= DIGIT_MAX) && (units_s <= DIGIT_MAX);
    sw_paired = rate_s[RATE_MODE_BIT];
    // odd id looks up, even id looks down
    if (sw_id[0])
      sw_peer = sw_id + NODE_ONE;
    else
      sw_peer = sw_id - NODE_ONE;
    for_me = NMT_IN.valid &&
      ((NMT_IN.node == NMT_ALL_NODES) || (NMT_IN.node == q.node_id));

    // ***************************************************************
    // network management
    // ***************************************************************
    case (q.nmt)
      ST_INIT:
      begin
        // switches are read only here, so turning them has no effect
        // until the node next re-enters init on a reset or either nmt reset command
        d.node_id = sw_id;
        d.peer_id = sw_peer;
        d.rate = rate_s[2:0];
        d.paired = sw_paired;
        d.id_ok = digits_ok && (sw_id <= MAX_NODE_ID);
        d.do_val = DO_RESET;
        // synchronisers reset to zero: deciding before they fill
        // would read id 0 and fall into firmware update
        if (q.settle != SYNC_SETTLE)
        begin
          d.settle = q.settle + 2'h1;
          d.nmt = ST_INIT;
        end
        else if (!digits_ok || (sw_id > MAX_NODE_ID))
          d.nmt = ST_INIT;
        else if (sw_id == FW_NODE_ID)
          d.nmt = ST_FWUPD;
        else if (sw_paired)
          d.nmt = ST_OPER;
        else
          d.nmt = ST_PREOP;
      end
      ST_PREOP, ST_OPER, ST_STOP:
      begin
        if (for_me)
        begin
          case (NMT_IN.cs)
            NMT_START: d.nmt = ST_OPER;
            NMT_STOP: d.nmt = ST_STOP;
            NMT_PREOP: d.nmt = ST_PREOP;
            NMT_RESET_NODE, NMT_RESET_COMM: d.nmt = ST_INIT;
            default: d.nmt = q.nmt;
          endcase
        end
      end
      ST_FWUPD: d.nmt = ST_FWUPD;
      default: d.nmt = ST_INIT;
    endcase

    case (q.nmt)
      ST_STOP: d.run_mode = LED_SINGLE;
      ST_PREOP: d.run_mode = LED_BLINK;
      ST_OPER: d.run_mode = LED_ON;
      default: d.run_mode = LED_OFF;
    endcase
    if (ERR_IN.busoff)
      d.err_mode = LED_ON;
    else if (ERR_IN.guard)
      d.err_mode = LED_DOUBLE;
    else if (ERR_IN.warn)
      d.err_mode = LED_SINGLE;
    else
      d.err_mode = LED_OFF;

    // ***************************************************************
    // axi4-lite slave
    // ***************************************************************
    if (S_AXI_AWVALID && q.awready)
    begin
      d.awready = 1'b0;
      d.aw_got = 1'b1;
      d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      d.wready = 1'b0;
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA[7:0];
      d.wstrb0 = S_AXI_WSTRB[0];
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.bvalid = 1'b1;
      d.bresp = reg_hit(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      wr_ok = q.wstrb0;
    end
    if (q.bvalid && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (wr_ok)
    begin
      case (q.awaddr)
        REG_DI_POL: d.di_pol = q.wdata;
        REG_DO_POL: d.do_pol = q.wdata;
        REG_DO_CMD:
          if (q.nmt != ST_FWUPD && q.nmt != ST_INIT)
            d.do_val = q.wdata;
        default: d.di_pol = d.di_pol;
      endcase
    end

    st.err = ERR_IN;
    st.rate = q.rate;
    st.id_ok = q.id_ok;
    st.fw = (q.nmt == ST_FWUPD);
    st.paired = q.paired;
    st.nmt = q.nmt;
    nr.peer = q.peer_id;
    nr.node = q.node_id;
    if (S_AXI_ARVALID && q.arready)
    begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = reg_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR)
        REG_DI_POL: d.rdata = 32'(q.di_pol);
        REG_DO_POL: d.rdata = 32'(q.do_pol);
        REG_DO_CMD: d.rdata = 32'(q.do_val);
        REG_STATUS: d.rdata = st;
        REG_DI_STATE: d.rdata = 32'(di_state);
        REG_NODE: d.rdata = nr;
        REG_KBPS: d.rdata = 32'(KBPS_TABLE[q.rate]);
        default: d.rdata = '0;
      endcase
    end
    if (q.rvalid && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // ***************************************************************
    // process data
    // ***************************************************************
    if (q.nmt == ST_OPER)
    begin
      if (RX_PDO.valid)
        d.do_val = RX_PDO.data;
      // peer updates win over the master when both land together
      if (q.paired && PEER_IN.valid && (PEER_IN.id == q.peer_id))
        d.do_val = PEER_IN.data;
      // first frame after going operational seeds the peer's outputs
      if ((di_state != q.di_prev) || !q.was_oper)
      begin
        d.tx.valid = 1'b1;
        d.tx.data = di_state;
      end
    end
    d.di_prev = di_state;
    d.was_oper = (q.nmt == ST_OPER);
    d.do_pin = d.do_val ^ d.do_pol;
    d.fw = (d.nmt == ST_FWUPD);
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.di_pol <= POL_RESET;
      q.do_pol <= POL_RESET;
      q.do_val <= DO_RESET;
      q.nmt <= ST_INIT;
      q.run_mode <= LED_OFF;
      q.err_mode <= LED_OFF;
    end
    else
      q <= d;
  end

  // ***************************************************************
  // indicators
  // ***************************************************************
  cdn_led u_run_led (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(q.tick),
    .mode(q.run_mode),
    .led(RUN_LED)
  );

  cdn_led u_err_led (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(q.tick),
    .mode(q.err_mode),
    .led(ERR_LED)
  );

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RVALID = q.rvalid;
  assign DIGITAL_OUTPUT_CHANNEL = q.do_pin;
  assign TX_PDO = q.tx;
  assign NODE_ID = q.node_id;
  assign PEER_ID = q.peer_id;
  assign BITRATE_IDX = q.rate;
  assign PAIRED_MODE = q.paired;
  assign FW_UPDATE = q.fw;
  assign NMT_STATE = q.nmt;

endmodule

// ==== testbench/cdn_peer_model.sv ====
`timescale 1ns/1ps

module cdn_peer_model
  import cdn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // peer id (odd partner plus one) and its field inputs
  input wire logic [6:0] own_id,
  input wire logic [7:0] pins,
  // update toward the node under test
  output cdn_peer_type upd
);
  logic [7:0] sent_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sent_q <= 8'h00;
      upd <= '0;
    end
    else if (pins != sent_q)
    begin
      sent_q <= pins;
      upd <= {1'b1, own_id, pins};
    end
    else
    begin
      // idle lines flip so a stale update is never mistaken for a new one
      upd <= {1'b0, ~upd.id, ~upd.data};
    end
  end
endmodule

// ==== testbench/cdn_node_sva.sv ====
`timescale 1ns/1ps

module cdn_node_sva
  import cdn_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // switches and faults
  input wire logic [3:0] ID_TENS_SW,
  input wire logic [3:0] ID_UNITS_SW,
  input wire logic [3:0] RATE_SW,
  input wire cdn_err_type ERR_IN,
  // configuration and state
  input wire logic [6:0] NODE_ID,
  input wire logic [6:0] PEER_ID,
  input wire logic [2:0] BITRATE_IDX,
  input wire logic PAIRED_MODE,
  input wire logic FW_UPDATE,
  input wire cdn_nmt_state_type NMT_STATE,
  // pins
  input wire logic [7:0] DIGITAL_OUTPUT_CHANNEL,
  input wire logic RUN_LED,
  input wire logic ERR_LED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic up;
  // switches are only trusted once the node has left init normally
  assign up = NMT_STATE != ST_INIT && !FW_UPDATE;

  a_id_digits: assert property (
    up |-> NODE_ID == 7'(ID_TENS_SW * 10 + ID_UNITS_SW))
    else $error("node id differs from switches");
  a_id_range: assert property (
    up |-> NODE_ID <= MAX_NODE_ID && NODE_ID != FW_NODE_ID)
    else $error("node id out of range");
  a_fw_zero: assert property (
    $rose(FW_UPDATE) |-> ID_TENS_SW == 4'h0 && ID_UNITS_SW == 4'h0
      ##1 FW_UPDATE)
    else $error("firmware mode without zero id");
  a_mode_bit: assert property (
    up |-> PAIRED_MODE == RATE_SW[RATE_MODE_BIT])
    else $error("paired flag wrong");
  a_rate_idx: assert property (
    up |-> BITRATE_IDX == RATE_SW[2:0])
    else $error("bit rate index wrong");
  a_peer_odd: assert property (
    up && PAIRED_MODE && NODE_ID[0] |-> PEER_ID == NODE_ID + 7'h01)
    else $error("peer id wrong");
  a_auto_oper: assert property (
    $fell(NMT_STATE == ST_INIT) && !FW_UPDATE
      |-> NMT_STATE == (PAIRED_MODE ? ST_OPER : ST_PREOP))
    else $error("wrong state after init");
  a_out_idle: assert property (
    $rose(RST_N) |-> (DIGITAL_OUTPUT_CHANNEL == 8'h00) [*3])
    else $error("outputs active after reset");
  a_run_oper: assert property (
    (NMT_STATE == ST_OPER) [*4] |-> RUN_LED)
    else $error("run indicator dark while operational");
  a_err_busoff: assert property (
    ERR_IN.busoff [*4] |-> ERR_LED)
    else $error("error indicator dark in bus off");

  cover property (NMT_STATE == ST_OPER && PAIRED_MODE);
  cover property (FW_UPDATE);
  cover property (NMT_STATE == ST_STOP);
endmodule

bind cdn_node cdn_node_sva cdn_node_sva_inst (
  .CLK(CLK), .RST_N(RST_N), .ID_TENS_SW(ID_TENS_SW),
  .ID_UNITS_SW(ID_UNITS_SW), .RATE_SW(RATE_SW), .ERR_IN(ERR_IN),
  .NODE_ID(NODE_ID), .PEER_ID(PEER_ID), .BITRATE_IDX(BITRATE_IDX),
  .PAIRED_MODE(PAIRED_MODE), .FW_UPDATE(FW_UPDATE),
  .NMT_STATE(NMT_STATE), .DIGITAL_OUTPUT_CHANNEL(DIGITAL_OUTPUT_CHANNEL),
  .RUN_LED(RUN_LED), .ERR_LED(ERR_LED)
);

// ==== testbench/tb.sv ====
`timescale 1ns/1ps

module tb
  import cdn_pkg::*;
;
  // ***************************************************************
  // stimulus, wiring and bookkeeping
  // ***************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [3:0] tens = 4'h0;
  logic [3:0] units = 4'h0;
  logic [3:0] rate = 4'h0;
  logic [7:0] din = 8'h00;
  logic [7:0] pin = 8'h00;
  logic [6:0] pid = 7'h00;
  cdn_nmt_type nmt = '0;
  cdn_pdo_type rx = '0;
  cdn_err_type err = '0;
  cdn_peer_type pup;
  cdn_pdo_type tx;
  cdn_nmt_state_type st;
  logic awr, wrdy, bv, arr, rv, paired, fw, run, errled;
  logic [1:0] brs, rrs;
  logic [31:0] rdat;
  logic [7:0] dout;
  logic [6:0] node, peer;
  logic [2:0] bidx;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  logic [31:0] kbps [8] = '{32'h0a, 32'h14, 32'h32, 32'h7d, 32'hfa,
    32'h1f4, 32'h320, 32'h3e8};
  int num_errors = 0;
  int check_count = 0;

  always #20 clk = ~clk;

  cdn_node #(.FLASH_CYC(4)) cdn_node_inst (
    .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(brs),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .ID_TENS_SW(tens), .ID_UNITS_SW(units), .RATE_SW(rate),
    .DIGITAL_INPUT_CHANNEL(din), .DIGITAL_OUTPUT_CHANNEL(dout),
    .NMT_IN(nmt), .RX_PDO(rx), .PEER_IN(pup), .ERR_IN(err), .TX_PDO(tx),
    .NODE_ID(node), .PEER_ID(peer), .BITRATE_IDX(bidx),
    .PAIRED_MODE(paired), .FW_UPDATE(fw), .NMT_STATE(st),
    .RUN_LED(run), .ERR_LED(errled)
  );

  cdn_peer_model cdn_peer_model_inst (
    .clk(clk), .rst_n(rst_n), .own_id(pid), .pins(pin), .upd(pup)
  );

  task automatic conclude();
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // responses are matched in order against what the driver queued
  always @(posedge clk)
  begin
    if (rv && rr)
      chk({rrs, rdat}, rq.pop_front());
    if (bv && br)
      chk(34'(brs), bq.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] r);
    int n;
    @(posedge clk);
    bq.push_back(34'(r));
    awa <= a;
    wd <= 32'(d);
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wrdy)
        wv <= 1'b0;
    end
    while (!bv && n < 40);
    br <= 1'b0;
    if (!bv)
    begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    int n;
    @(posedge clk);
    rq.push_back({r, d});
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arv && arr)
        arv <= 1'b0;
    end
    while (!rv && n < 40);
    rr <= 1'b0;
    if (!rv)
    begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic rst_node(input logic [3:0] t, input logic [3:0] u,
    input logic [3:0] r);
    @(posedge clk);
    rst_n <= 1'b0;
    tens <= t;
    units <= u;
    rate <= r;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // bounded: a node that never gets there ends the run as a failure
  task automatic settle(input cdn_nmt_state_type s);
    int n;
    n = 0;
    while (st !== s && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (st !== s)
    begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic send_nmt(input logic [6:0] n, input logic [7:0] c);
    @(posedge clk);
    nmt <= {1'b1, n, c};
    @(posedge clk);
    nmt <= '0;
  endtask

  task automatic send_pdo(input logic [7:0] d);
    @(posedge clk);
    rx <= {1'b1, d};
    @(posedge clk);
    rx <= '0;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  initial
  begin
    int id;
    int n;
    logic [7:0] d;
    logic [7:0] p;
    void'($urandom(32'h5fe1));
    rst_node(4'h1, 4'h2, 4'h3);
    settle(ST_PREOP);
    chk(34'(st), 34'(ST_PREOP));
    chk(34'(node), 34'h0c);
    chk(34'(bidx), 34'h3);
    chk(34'(dout), 34'h0);
    rd(REG_KBPS, 32'h7d, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    send_nmt(7'h0c, NMT_START);
    settle(ST_OPER);
    chk(34'(st), 34'(ST_OPER));
    d = 8'($urandom);
    send_pdo(d);
    @(posedge clk);
    chk(34'(dout), 34'(d));
    chk(34'(run), 34'h1);
    p = 8'($urandom);
    wr(REG_DO_POL, p, RESP_OKAY);
    @(posedge clk);
    chk(34'(dout), 34'(d ^ p));
    d = 8'($urandom);
    din <= d;
    wr(REG_DI_POL, p, RESP_OKAY);
    rd(REG_DI_STATE, 32'(d ^ p), RESP_OKAY);
    err <= 3'h1;
    repeat (8) @(posedge clk);
    chk(34'(errled), 34'h1);
    err <= 3'h0;
    send_nmt(7'h0d, NMT_STOP);
    @(posedge clk);
    chk(34'(st), 34'(ST_OPER));
    send_nmt(NMT_ALL_NODES, NMT_STOP);
    settle(ST_STOP);
    chk(34'(st), 34'(ST_STOP));
    for (int c = 0; c < 16; c++)
    begin
      id = 1 + $urandom % 99;
      rst_node(4'(id / 10), 4'(id % 10), 4'(c));
      settle(c[3] ? ST_OPER : ST_PREOP);
      chk(34'(st), 34'(c[3] ? ST_OPER : ST_PREOP));
      chk(34'(paired), 34'(c[3]));
      chk(34'(node), 34'(id));
      chk(34'(bidx), 34'(c[2:0]));
      rd(REG_KBPS, kbps[c[2:0]], RESP_OKAY);
    end
    pid <= 7'h02;
    rst_node(4'h0, 4'h1, 4'hd);
    settle(ST_OPER);
    chk(34'(peer), 34'h2);
    d = 8'($urandom) | 8'h01;
    pin <= d;
    repeat (4) @(posedge clk);
    chk(34'(dout), 34'(d));
    // own inputs must travel to the peer once they change
    d = din ^ (8'($urandom) | 8'h01);
    din <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!tx.valid && n < 10);
    chk(34'(tx), 34'({1'b1, d}));
    if (!tx.valid)
      conclude();
    rst_node(4'h9, 4'h9, 4'h0);
    settle(ST_PREOP);
    chk(34'(node), 34'h63);
    rst_node(4'h0, 4'h0, 4'h0);
    settle(ST_FWUPD);
    chk(34'(fw), 34'h1);
    send_nmt(NMT_ALL_NODES, NMT_START);
    @(posedge clk);
    chk(34'(st), 34'(ST_FWUPD));
    rst_node(4'ha, 4'h0, 4'h0);
    repeat (10) @(posedge clk);
    chk(34'(st), 34'(ST_INIT));
    conclude();
  end
endmodule
